// ==== design/lbhs_pkg.sv ====
// Purpose: Shared constants and carriers for the local bus hold and select block
// Assumes: One clock, synchronous active-high reset
// Notes:   Select ranges arrive as plain configuration inputs
package lbhs_pkg;

    localparam int LBHS_SYNC_STAGES = 2;
    localparam int LBHS_MID_SELS    = 4;
    localparam int LBHS_PER_SELS    = 7;
    localparam int LBHS_ADDR_W      = 20;
    localparam int LBHS_IO_ADDR_W   = 16;
    localparam int LBHS_RESET_DRIVE = 1;
    localparam logic [1:0] LBHS_LATCH_RST = 2'h0;

    // One address range, inclusive bounds
    typedef struct packed {
        logic [LBHS_ADDR_W-1:0] base;
        logic [LBHS_ADDR_W-1:0] limit;
    } lbhs_range_t;

    // Bus cycle request from the execution side
    typedef struct packed {
        logic                   valid;
        logic                   is_mem;
        logic                   is_write;
        logic [LBHS_ADDR_W-1:0] addr;
    } lbhs_cycle_t;

    // Select range configuration
    typedef struct packed {
        lbhs_range_t                     upper;
        lbhs_range_t                     lower;
        lbhs_range_t [LBHS_MID_SELS-1:0] mid;
        lbhs_range_t [LBHS_PER_SELS-1:0] per;
        logic                            pins_as_addr;
    } lbhs_cfg_t;

endpackage : lbhs_pkg

// ==== design/lbhs_sync.sv ====
// Purpose: Multi-flop synchroniser for an asynchronous level
// Assumes: Destination clock ref_clk
// Notes:   First stage feeds only the next stage
`timescale 1ns/1ps
module lbhs_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);
    import lbhs_pkg::*;

    typedef struct packed {
        logic [STAGES-1:0] chain;
    } lbhs_sync_state_t;

    lbhs_sync_state_t state_ff;
    lbhs_sync_state_t nxt_state;

    // Shift the level down the chain
    always_comb
    begin
        nxt_state.chain = {state_ff.chain[STAGES-2:0], async_in};
    end

    // Register the chain
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.chain[STAGES-1];

endmodule : lbhs_sync

// ==== design/lbhs_top.sv ====
// Purpose: Local bus hold handshake, chip selects and transceiver control
// Assumes: cycle_last marks the last bus cycle state; ranges come from config inputs
// Notes:   Two-way outputs use value plus output enable, enable high = driving
// What this block does
// - Grant hold at end of last bus cycle state or an idle state.
// - Float address/data and control outputs in the same clock as the grant.
// - Drop the grant once the synchronised hold request reads low.
// - After release, drive bus and control again in the clock the grant drops.
// - Upper memory select low for memory references in the top region.
// - Lower memory select low for memory references in the bottom region.
// - Four mid memory selects, each low within its part of mid region.
// - Five peripheral selects, each low for I/O access in its range.
// - Memory and peripheral selects always driven, also during hold.
// - Two pins act as selects six and seven or latched address bits one, two.
// - In address mode those pins keep their latched values during hold.
// - Direction low while reading into processor, high while writing.
// - Transceiver enable low during every memory and I/O access.
// - Transceiver enable high whenever direction changes level.
// - In reset drive transceiver enable high from the first clock edge until reset ends.
// - Float transceiver enable throughout a hold.
`timescale 1ns/1ps
module lbhs_top (
    // Clock and reset
    input  wire logic                                      ref_clk,
    input  wire logic                                      sys_rst,
    // Hold handshake
    input  wire logic                                      hold_req,
    output logic                                           hold_grant,
    // Bus cycle from the core
    input  wire lbhs_pkg::lbhs_cycle_t                     cycle_in,
    input  wire logic                                      cycle_last,
    output logic                                           cycle_stall,
    // Select configuration
    input  wire lbhs_pkg::lbhs_cfg_t                       sel_cfg,
    // Bus output enables
    output logic                                           bus_drive_en,
    // Chip selects
    output logic                                           upper_memory_select_n,
    output logic                                           lower_memory_select_n,
    output logic [lbhs_pkg::LBHS_MID_SELS-1:0]             mid_memory_select_n,
    output logic [4:0]                                     peripheral_select_n,
    output logic                                           periph_sel5_or_latched_addr1,
    output logic                                           periph_sel6_or_latched_addr2,
    // Transceiver control
    output logic                                           transceiver_direction,
    output logic                                           transceiver_direction_oe,
    output logic                                           transceiver_enable_n,
    output logic                                           transceiver_enable_n_oe
);
    import lbhs_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_XFER  = 4'h2,
        ST_TURN  = 4'h4,
        ST_HOLD  = 4'h8
    } lbhs_st_t;

    typedef struct packed {
        lbhs_st_t                 st;
        logic                     grant;
        logic                     rst_drive;
        logic                     dir;
        logic                     en_n;
        logic                     upper_n;
        logic                     lower_n;
        logic [LBHS_MID_SELS-1:0] mid_n;
        logic [LBHS_PER_SELS-1:0] per_n;
        logic [1:0]               latch_a;
        logic                     write_q;
    } lbhs_state_t;

    lbhs_state_t state_ff;
    lbhs_state_t nxt_state;
    logic        hold_sync;
    logic        hit_upper;
    logic        hit_lower;
    logic [LBHS_MID_SELS-1:0] hit_mid;
    logic [LBHS_PER_SELS-1:0] hit_per;

    // Hold request is asynchronous, so it is synchronised first
    lbhs_sync #(
        .STAGES   (LBHS_SYNC_STAGES)
    ) u_hold_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (hold_req),
        .sync_out (hold_sync)
    );

    // Range decode for memory selects
    assign hit_upper = cycle_in.valid && cycle_in.is_mem
                       && cycle_in.addr >= sel_cfg.upper.base
                       && cycle_in.addr <= sel_cfg.upper.limit;
    assign hit_lower = cycle_in.valid && cycle_in.is_mem
                       && cycle_in.addr >= sel_cfg.lower.base
                       && cycle_in.addr <= sel_cfg.lower.limit;

    // One decoder per mid and peripheral select
    genvar gi;
    generate
        for (gi = 0; gi < LBHS_MID_SELS; gi++)
        begin : g_mid
            assign hit_mid[gi] = cycle_in.valid && cycle_in.is_mem
                                 && cycle_in.addr >= sel_cfg.mid[gi].base
                                 && cycle_in.addr <= sel_cfg.mid[gi].limit;
        end
        for (gi = 0; gi < LBHS_PER_SELS; gi++)
        begin : g_per
            assign hit_per[gi] = cycle_in.valid && !cycle_in.is_mem
                                 && cycle_in.addr[LBHS_IO_ADDR_W-1:0]
                                    >= sel_cfg.per[gi].base[LBHS_IO_ADDR_W-1:0]
                                 && cycle_in.addr[LBHS_IO_ADDR_W-1:0]
                                    <= sel_cfg.per[gi].limit[LBHS_IO_ADDR_W-1:0];
        end
    endgenerate

    // Next-state logic for the bus sequencer and pin values
    always_comb
    begin
        nxt_state           = state_ff;
        nxt_state.rst_drive = 1'b0;
        unique case (state_ff.st)
            ST_IDLE:
            begin
                if (hold_sync)
                begin
                    // Idle state ends: grant and float together
                    nxt_state.st    = ST_HOLD;
                    nxt_state.grant = 1'b1;
                    nxt_state.en_n  = 1'b1;
                end
                else if (cycle_in.valid)
                begin
                    nxt_state.upper_n = !hit_upper;
                    nxt_state.lower_n = !hit_lower;
                    nxt_state.mid_n   = ~hit_mid;
                    nxt_state.per_n   = ~hit_per;
                    nxt_state.latch_a = cycle_in.addr[2:1];
                    nxt_state.write_q = cycle_in.is_write;
                    if (state_ff.dir != cycle_in.is_write)
                    begin
                        // Turn the transceiver with enable held high
                        nxt_state.st   = ST_TURN;
                        nxt_state.dir  = cycle_in.is_write;
                        nxt_state.en_n = 1'b1;
                    end
                    else
                    begin
                        nxt_state.st   = ST_XFER;
                        nxt_state.en_n = 1'b0;
                    end
                end
            end
            ST_TURN:
            begin
                nxt_state.st   = ST_XFER;
                nxt_state.en_n = 1'b0;
            end
            ST_XFER:
            begin
                if (cycle_last)
                begin
                    nxt_state.en_n    = 1'b1;
                    nxt_state.upper_n = 1'b1;
                    nxt_state.lower_n = 1'b1;
                    nxt_state.mid_n   = '1;
                    nxt_state.per_n   = '1;
                    if (hold_sync)
                    begin
                        // End of the last bus cycle state
                        nxt_state.st    = ST_HOLD;
                        nxt_state.grant = 1'b1;
                    end
                    else
                    begin
                        nxt_state.st = ST_IDLE;
                    end
                end
            end
            ST_HOLD:
            begin
                if (!hold_sync)
                begin
                    nxt_state.st    = ST_IDLE;
                    nxt_state.grant = 1'b0;
                end
            end
            default:
            begin
                nxt_state.st = ST_IDLE;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff           <= '0;
            state_ff.st        <= ST_IDLE;
            state_ff.rst_drive <= 1'(LBHS_RESET_DRIVE);
            state_ff.en_n      <= 1'b1;
            state_ff.upper_n   <= 1'b1;
            state_ff.lower_n   <= 1'b1;
            state_ff.mid_n     <= '1;
            state_ff.per_n     <= '1;
            state_ff.latch_a   <= LBHS_LATCH_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Core waits while the bus is held, the transceiver turns or a cycle runs
    assign cycle_stall = (state_ff.st == ST_HOLD) || (state_ff.st == ST_TURN) || (state_ff.st == ST_XFER)
                         || (state_ff.st == ST_IDLE && hold_sync);

    // Bus and control float with the grant, resume when not held
    assign hold_grant   = state_ff.grant;
    assign bus_drive_en = !state_ff.grant && !sys_rst;

    // Selects are always driven; pins 5/6 switch role by config
    assign upper_memory_select_n = state_ff.upper_n;
    assign lower_memory_select_n = state_ff.lower_n;
    assign mid_memory_select_n   = state_ff.mid_n;
    assign peripheral_select_n   = state_ff.per_n[4:0];
    assign periph_sel5_or_latched_addr1 = sel_cfg.pins_as_addr ? state_ff.latch_a[0]
                                                               : state_ff.per_n[5];
    assign periph_sel6_or_latched_addr2 = sel_cfg.pins_as_addr ? state_ff.latch_a[1]
                                                               : state_ff.per_n[6];

    // Transceiver pins float during hold; in reset direction floats and enable is driven high
    assign transceiver_direction    = state_ff.dir;
    assign transceiver_direction_oe = !state_ff.grant && !sys_rst;
    assign transceiver_enable_n     = state_ff.en_n || state_ff.rst_drive;
    assign transceiver_enable_n_oe  = state_ff.rst_drive
                                      || (!state_ff.grant && !sys_rst);

endmodule : lbhs_top

// ==== tb/lbhs_chk.sv ====
// Purpose: Assertions on the hold handshake, selects and transceiver pins
// Assumes: Select configuration is held steady while cycles run
// Notes:   Two sync stages put three samples between request and grant
`timescale 1ns/1ps
module lbhs_chk (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  sys_rst,
    // Hold and cycle
    input wire logic                  hold_req,
    input wire logic                  hold_grant,
    input wire lbhs_pkg::lbhs_cycle_t cycle_in,
    input wire logic                  cycle_stall,
    input wire lbhs_pkg::lbhs_cfg_t   sel_cfg,
    // Pins
    input wire logic                  bus_drive_en,
    input wire logic                  upper_memory_select_n,
    input wire logic                  periph_sel5_or_latched_addr1,
    input wire logic                  periph_sel6_or_latched_addr2,
    input wire logic                  transceiver_direction,
    input wire logic                  transceiver_direction_oe,
    input wire logic                  transceiver_enable_n,
    input wire logic                  transceiver_enable_n_oe
);
    import lbhs_pkg::*;
    logic take;
    logic en_on;
    logic wr_ff;
    logic rst_seen_ff;
    // Set once an edge inside reset has settled the design's state
    always_ff @(posedge ref_clk)
        if (sys_rst)
            rst_seen_ff <= 1'b1;
    // Request taken and transceiver enabled
    assign take  = cycle_in.valid && !cycle_stall;
    assign en_on = !transceiver_enable_n && transceiver_enable_n_oe;
    // Direction of the last cycle taken
    always_ff @(posedge ref_clk)
        if (take)
            wr_ff <= cycle_in.is_write;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_float; hold_grant |-> !bus_drive_en && !transceiver_enable_n_oe && !transceiver_direction_oe; endproperty
    a_float: assert property (p_float) else $error("bus driven in hold");
    property p_sync; $rose(hold_grant) |-> $past(hold_req, 3); endproperty
    a_sync: assert property (p_sync) else $error("grant too early");
    property p_rel; hold_grant && $fell(hold_req) |-> ##[1:3] !hold_grant; endproperty
    a_rel: assert property (p_rel) else $error("grant not dropped");
    property p_mid; en_on |-> !hold_grant; endproperty
    a_mid: assert property (p_mid) else $error("grant inside cycle");
    property p_en; take |-> ##[1:2] en_on; endproperty
    a_en: assert property (p_en) else $error("no enable");
    property p_dir; en_on |-> transceiver_direction == wr_ff && transceiver_direction_oe && bus_drive_en; endproperty
    a_dir: assert property (p_dir) else $error("bad direction");
    property p_turn; $changed(transceiver_direction) && transceiver_direction_oe |-> transceiver_enable_n; endproperty
    a_turn: assert property (p_turn) else $error("enable low on turn");
    property p_rst;
        disable iff (1'b0) sys_rst && rst_seen_ff |-> transceiver_enable_n || !transceiver_enable_n_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("enable low in reset");
    property p_up;
        take && cycle_in.is_mem && cycle_in.addr >= sel_cfg.upper.base && cycle_in.addr <= sel_cfg.upper.limit
            |=> !upper_memory_select_n;
    endproperty
    a_up: assert property (p_up) else $error("upper select missing");
    property p_hold_pins;
        hold_grant && $past(hold_grant) && sel_cfg.pins_as_addr
            |-> $stable(periph_sel5_or_latched_addr1) && $stable(periph_sel6_or_latched_addr2);
    endproperty
    a_hold_pins: assert property (p_hold_pins) else $error("latched bits moved");
    c_grant: cover property ($rose(hold_grant));
    c_turn: cover property ($changed(transceiver_direction));
    c_refused: cover property (cycle_in.valid && cycle_stall);
endmodule : lbhs_chk
bind lbhs_top lbhs_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .hold_req(hold_req), .hold_grant(hold_grant),
    .cycle_in(cycle_in), .cycle_stall(cycle_stall), .sel_cfg(sel_cfg), .bus_drive_en(bus_drive_en),
    .upper_memory_select_n(upper_memory_select_n), .periph_sel5_or_latched_addr1(periph_sel5_or_latched_addr1),
    .periph_sel6_or_latched_addr2(periph_sel6_or_latched_addr2), .transceiver_direction(transceiver_direction),
    .transceiver_direction_oe(transceiver_direction_oe), .transceiver_enable_n(transceiver_enable_n),
    .transceiver_enable_n_oe(transceiver_enable_n_oe));

// ==== tb/lbhs_hold_master.sv ====
// Purpose: Outside bus master that raises and drops the hold request
// Assumes: Request edges fall off the ref_clk grid
// Notes:   A drop waits until the grant has been seen
`timescale 1ns/1ps
module lbhs_hold_master (
    // Bench control
    input  wire logic want,
    // Handshake
    input  wire logic hold_grant,
    output logic      hold_req
);
    // Request follows want after an odd delay, unrelated to the clock
    initial hold_req = 1'b0;
    always @(want or hold_grant)
        if (want || hold_grant)
            hold_req <= #3.3 want;
endmodule : lbhs_hold_master

// ==== tb/tb_top.sv ====
// Purpose: Corner and random bus cycles with hold handovers
// Assumes: Hold master model drives hold_req off the clock grid
// Notes:   Expected pins come from the configured ranges
`timescale 1ns/1ps
module tb_top;
    import lbhs_pkg::*;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, want = 1'b0, cycle_last = 1'b0;
    logic        hold_req, hold_grant, cycle_stall, bus_drive_en, dir, dir_oe, en_n, en_n_oe, ums, lms, p5, p6;
    logic [3:0]  mms;
    logic [4:0]  pms;
    logic [1:0]  lat = 2'h0;
    lbhs_cycle_t cyc = '0;
    lbhs_cfg_t   cfg = '0;
    int          fail_count = 0, checked = 0, i;
    logic [19:0] corner [6] = '{20'h3FFFF, 20'h40000, 20'h7FFFF, 20'hBFFFF, 20'hC0000, 20'h006FF};
    wire  [15:0] pins = {3'h0, ums, lms, mms, pms, p5, p6};
    always #5 ref_clk = ~ref_clk;
    lbhs_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hold_req(hold_req), .hold_grant(hold_grant),
        .cycle_in(cyc), .cycle_last(cycle_last), .cycle_stall(cycle_stall), .sel_cfg(cfg), .bus_drive_en(bus_drive_en),
        .upper_memory_select_n(ums), .lower_memory_select_n(lms), .mid_memory_select_n(mms),
        .peripheral_select_n(pms), .periph_sel5_or_latched_addr1(p5), .periph_sel6_or_latched_addr2(p6),
        .transceiver_direction(dir), .transceiver_direction_oe(dir_oe), .transceiver_enable_n(en_n),
        .transceiver_enable_n_oe(en_n_oe));
    lbhs_hold_master u_master (.want(want), .hold_grant(hold_grant), .hold_req(hold_req));
    // Comparison, clock step and closing
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : cmp
    task automatic step(inout int n);
        @(posedge ref_clk);
        #1 n++;
    endtask : step
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Select pins expected while a cycle is active
    function automatic logic [15:0] exp_act(lbhs_cycle_t c);
        logic [15:0] r;
        r = 16'h1FFF;
        r[12] = !(c.is_mem && c.addr >= cfg.upper.base && c.addr <= cfg.upper.limit);
        r[11] = !(c.is_mem && c.addr >= cfg.lower.base && c.addr <= cfg.lower.limit);
        for (int k = 0; k < 4; k++)
            r[7+k] = !(c.is_mem && c.addr >= cfg.mid[k].base && c.addr <= cfg.mid[k].limit);
        for (int k = 0; k < 7; k++)
            r[k < 5 ? 2 + k : 6 - k] = !(!c.is_mem && c.addr[15:0] >= cfg.per[k].base[15:0]
                && c.addr[15:0] <= cfg.per[k].limit[15:0]);
        if (cfg.pins_as_addr)
            r[1:0] = {c.addr[1], c.addr[2]};
        return r;
    endfunction : exp_act
    // One whole cycle; hm raises a hold in mid transfer
    task automatic run_cycle(input lbhs_cycle_t c, input logic hm);
        int n;
        n = 0;
        cyc = c;
        while (cycle_stall !== 1'b0 && n < 20) step(n);
        if (n >= 20)
            fail_count++;
        step(n);
        cyc.valid = 1'b0;
        n = 0;
        while (en_n !== 1'b0 && n < 3) step(n);
        cmp(pins, exp_act(c));
        cmp({dir, dir_oe, bus_drive_en, en_n, en_n_oe}, {c.is_write, 4'hD});
        if (hm)
        begin
            want = 1'b1;
            repeat (6) step(n);
            cmp(hold_grant, 1'b0);
        end
        cycle_last = 1'b1;
        step(n);
        cycle_last = 1'b0;
        if (cfg.pins_as_addr)
            lat = {c.addr[1], c.addr[2]};
        cmp(pins, {3'h0, 11'h7FF, cfg.pins_as_addr ? lat : 2'h3});
    endtask : run_cycle
    function automatic lbhs_cycle_t rnd();
        return '{1'b1, 1'($urandom), 1'($urandom), {4'($urandom), 16'($urandom)}};
    endfunction : rnd
    // Watchdog
    initial
    begin
        #100000 fail_count++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        int n;
        cfg.upper = '{20'hC0000, 20'hFFFFF};
        cfg.lower = '{20'h00000, 20'h3FFFF};
        for (i = 0; i < 4; i++) cfg.mid[i] = '{20'h40000 + 20'(i) * 20'h10000, 20'h4FFFF + 20'(i) * 20'h10000};
        for (i = 0; i < 7; i++) cfg.per[i] = '{20'(i) << 8, (20'(i) << 8) + 20'hFF};
        void'($urandom(32'h3926));
        repeat (4) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        for (i = 0; i < 6; i++)
        begin
            run_cycle('{1'b1, 1'b1, 1'b0, corner[i]}, 1'b0);
            run_cycle('{1'b1, 1'b0, 1'b1, corner[i]}, 1'b0);
        end
        $display("corner test done");
        for (i = 0; i < 60; i++)
        begin
            cfg.pins_as_addr = (i >= 30);
            run_cycle(rnd(), 1'b0);
        end
        $display("random test done");
        run_cycle(rnd(), 1'b1);
        n = 0;
        while (hold_grant !== 1'b1 && n < 6) step(n);
        if (n >= 6)
            fail_count++;
        cmp({hold_grant, bus_drive_en, en_n_oe, dir_oe}, 16'h8);
        cyc = rnd();
        repeat (3) step(n);
        cmp({cycle_stall, pins[1:0]}, {1'b1, lat});
        want = 1'b0;
        run_cycle(cyc, 1'b0);
        $display("hold test done");
        end_of_test();
    end
endmodule : tb_top
